/* File: prog_entry_pkg.sv */
// Package with constants shared by both ends of the programming entry link.
package prog_entry_pkg;
  localparam int KEY_BITS = 32;
  localparam logic [31:0] ENTRY_KEY = 32'h5A3C_96E1; // Arbitrary default key.
  localparam int CMD_BITS = 6;
  localparam int WORD_BITS = 16;
  localparam logic [5:0] CMD_WRITE_PROG = 6'h02;
  localparam logic [5:0] CMD_WRITE_ID = 6'h03;
  localparam logic [5:0] CMD_WRITE_CFG = 6'h04;
  localparam logic [5:0] CMD_CLEAR_LV_ENABLE = 6'h05;
  localparam int CLK_DIV = 4; // Half period of the link clock in clk cycles.
  localparam logic [1:0] WR_PROG = 2'h0;
  localparam logic [1:0] WR_ID = 2'h1;
  localparam logic [1:0] WR_CFG = 2'h2;
endpackage

/* File: prog_link_if.sv */
// Interface joining the programmer and the device over the serial pins.
`timescale 1ns/1ps
`default_nettype none
interface prog_link_if;
  logic progSerialClock;
  logic dataFromHost;
  logic dataHostOe;
  logic dataFromDev;
  logic dataDevOe;
  logic resetPinLevel;
  logic highVoltage;
  wire progSerialData;
  // Resolved data line: pulled low when nobody drives.
  assign progSerialData = dataHostOe ? dataFromHost :
                          (dataDevOe ? dataFromDev : 1'b0);
  modport device (input progSerialClock, input dataFromHost, input dataHostOe,
                  output dataFromDev, output dataDevOe,
                  input resetPinLevel, input highVoltage,
                  input progSerialData);
  modport host (output progSerialClock, output dataFromHost,
                output dataHostOe, input dataFromDev, input dataDevOe,
                output resetPinLevel, output highVoltage,
                input progSerialData);
endinterface
`default_nettype wire

/* File: prog_entry_device.sv */
// Device end: programming mode entry and serial write decoding.
// Summary of operation
// RULE1 - Data line two-way, clock line input only; this device never drives the data line.
// RULE2 - Program mode accepts memory, ID, config writes.
// RULE3 - Clock, data low, then high voltage enters.
// RULE4 - Low-voltage entry only while enable bit set.
// RULE5 - Reset low, then shift 32-bit key.
// RULE6 - Low-voltage session lasts while reset low.
// RULE7 - Enable bit set forces external reset on.
// RULE8 - Enable bit cleared only in high-voltage session.
// RULE9 - Bad key or early reset rise aborts.
`timescale 1ns/1ps
`default_nettype none
module prog_entry_device
  import prog_entry_pkg::*;
#(
  parameter logic [31:0] KEY = ENTRY_KEY,
  parameter logic LV_ENABLE_DEFAULT = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  prog_link_if.device link,
  input wire logic resetDisableCfg,
  output logic lowVoltageProgEnable,
  output logic externalResetPinEnable,
  output logic progMode,
  output logic hvSession,
  output logic writeStrobe,
  output logic [1:0] writeKind,
  output logic [WORD_BITS-1:0] writeData
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_KEY = 3'b001,
    ST_CMD = 3'b010,
    ST_DATA = 3'b011
  } state_t;

  state_t state_r, state_nxt;
  logic [2:0] clkSync_r, datSync_r, rstSync_r, hvSync_r;
  logic [2:0] clkSync_nxt, datSync_nxt, rstSync_nxt, hvSync_nxt;
  logic [31:0] shift_r, shift_nxt;
  logic [5:0] count_r, count_nxt;
  logic [CMD_BITS-1:0] cmd_r, cmd_nxt;
  logic lvEnable_r, lvEnable_nxt, hv_r, hv_nxt, mode_r, mode_nxt;
  logic ext_r, ext_nxt, wr_r, wr_nxt;
  logic [1:0] kind_r, kind_nxt;
  logic [WORD_BITS-1:0] wdata_r, wdata_nxt;
  logic clkRise, dat, rstPin, hvIn;

  // Two flip-flops before use; the third stage only serves edge detection.
  always_comb begin
    clkSync_nxt = {clkSync_r[1:0], link.progSerialClock}; // RULE1
    datSync_nxt = {datSync_r[1:0], link.progSerialData};
    rstSync_nxt = {rstSync_r[1:0], link.resetPinLevel};
    hvSync_nxt = {hvSync_r[1:0], link.highVoltage};
    clkRise = clkSync_r[1] & ~clkSync_r[2];
    dat = datSync_r[1];
    rstPin = rstSync_r[1];
    hvIn = hvSync_r[1];
  end

  // Entry sequencing, key check and command decode.
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    count_nxt = count_r;
    cmd_nxt = cmd_r;
    lvEnable_nxt = lvEnable_r;
    hv_nxt = hv_r;
    mode_nxt = mode_r;
    wr_nxt = 1'b0;
    kind_nxt = kind_r;
    wdata_nxt = wdata_r;
    ext_nxt = lvEnable_r | ~resetDisableCfg; // RULE7
    case (state_r)
      ST_IDLE: begin
        shift_nxt = '0;
        count_nxt = '0;
        if (hvIn && !clkSync_r[1] && !dat) begin // RULE3
          hv_nxt = 1'b1;
          mode_nxt = 1'b1;
          state_nxt = ST_CMD;
        end else if (lvEnable_r && !rstPin) begin // RULE4
          state_nxt = ST_KEY;
        end
      end
      ST_KEY: begin
        if (rstPin || !lvEnable_r) begin // RULE9
          state_nxt = ST_IDLE;
        end else if (clkRise) begin
          shift_nxt = {shift_r[30:0], dat}; // RULE5
          count_nxt = count_r + 6'h01;
          if (count_r == 6'(KEY_BITS - 1)) begin
            count_nxt = '0;
            if ({shift_r[30:0], dat} == KEY) begin
              mode_nxt = 1'b1;
              state_nxt = ST_CMD;
            end else begin
              state_nxt = ST_IDLE; // RULE9
            end
          end
        end
      end
      ST_CMD, ST_DATA: begin
        if ((hv_r && !hvIn) || (!hv_r && rstPin)) begin // RULE6
          mode_nxt = 1'b0;
          hv_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end else if (clkRise) begin
          shift_nxt = {shift_r[30:0], dat};
          count_nxt = count_r + 6'h01;
          if (state_r == ST_CMD && count_r == 6'(CMD_BITS - 1)) begin
            cmd_nxt = {shift_r[4:0], dat};
            count_nxt = '0;
            if ({shift_r[4:0], dat} == CMD_CLEAR_LV_ENABLE) begin
              if (hv_r) begin
                lvEnable_nxt = 1'b0; // RULE8
              end
            end else if ({shift_r[4:0], dat} == CMD_WRITE_PROG ||
                         {shift_r[4:0], dat} == CMD_WRITE_ID ||
                         {shift_r[4:0], dat} == CMD_WRITE_CFG) begin
              state_nxt = ST_DATA;
            end
          end else if (state_r == ST_DATA &&
                       count_r == 6'(WORD_BITS - 1)) begin
            count_nxt = '0;
            wr_nxt = 1'b1; // RULE2
            wdata_nxt = {shift_r[14:0], dat};
            kind_nxt = (cmd_r == CMD_WRITE_PROG) ? WR_PROG :
                       (cmd_r == CMD_WRITE_ID) ? WR_ID : WR_CFG;
            state_nxt = ST_CMD;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      clkSync_r <= 3'h0;
      datSync_r <= 3'h0;
      rstSync_r <= 3'h7;
      hvSync_r <= 3'h0;
      shift_r <= 32'h0000_0000;
      count_r <= 6'h00;
      cmd_r <= 6'h00;
      lvEnable_r <= LV_ENABLE_DEFAULT;
      hv_r <= 1'b0;
      mode_r <= 1'b0;
      ext_r <= 1'b1;
      wr_r <= 1'b0;
      kind_r <= 2'h0;
      wdata_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      clkSync_r <= clkSync_nxt;
      datSync_r <= datSync_nxt;
      rstSync_r <= rstSync_nxt;
      hvSync_r <= hvSync_nxt;
      shift_r <= shift_nxt;
      count_r <= count_nxt;
      cmd_r <= cmd_nxt;
      lvEnable_r <= lvEnable_nxt;
      hv_r <= hv_nxt;
      mode_r <= mode_nxt;
      ext_r <= ext_nxt;
      wr_r <= wr_nxt;
      kind_r <= kind_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // The device never drives data back in this write-only block.
  assign link.dataFromDev = 1'b0; // RULE1
  assign link.dataDevOe = 1'b0;
  assign lowVoltageProgEnable = lvEnable_r;
  assign externalResetPinEnable = ext_r;
  assign progMode = mode_r;
  assign hvSession = hv_r;
  assign writeStrobe = wr_r;
  assign writeKind = kind_r;
  assign writeData = wdata_r;
endmodule // prog_entry_device
`default_nettype wire

/* File: prog_entry_host.sv */
// Programmer end: drives entry sequences and shifts commands and data.
`timescale 1ns/1ps
`default_nettype none
module prog_entry_host
  import prog_entry_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  prog_link_if.host link,
  input wire logic startLv,
  input wire logic startHv,
  input wire logic stop,
  input wire logic sendReq,
  input wire logic [CMD_BITS-1:0] sendCmd,
  input wire logic sendHasData,
  input wire logic [WORD_BITS-1:0] sendData,
  output logic busy,
  output logic inSession
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SHIFT = 2'b01,
    H_SESSION = 2'b10
  } hstate_t;

  hstate_t st_r, st_nxt;
  logic [53:0] sh_r, sh_nxt;
  logic [5:0] left_r, left_nxt;
  logic [2:0] div_r, div_nxt;
  logic sck_r, sck_nxt, dat_r, dat_nxt, oe_r, oe_nxt;
  logic rstPin_r, rstPin_nxt, hv_r, hv_nxt, sess_r, sess_nxt;
  logic busy_r, busy_nxt;

  // Sequencer: shifts MSB first, data changes on the same clk edge that raises the link clock.
  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    left_nxt = left_r;
    div_nxt = div_r;
    sck_nxt = sck_r;
    dat_nxt = dat_r;
    oe_nxt = oe_r;
    rstPin_nxt = rstPin_r;
    hv_nxt = hv_r;
    sess_nxt = sess_r;
    case (st_r)
      H_IDLE: begin
        sck_nxt = 1'b0;
        dat_nxt = 1'b0;
        if (startHv) begin
          oe_nxt = 1'b1; // RULE3
          hv_nxt = 1'b1;
          sess_nxt = 1'b1;
          st_nxt = H_SESSION;
        end else if (startLv) begin
          oe_nxt = 1'b1;
          rstPin_nxt = 1'b0; // RULE5
          sh_nxt = {ENTRY_KEY, 22'h00_0000};
          left_nxt = 6'(KEY_BITS);
          div_nxt = '0;
          st_nxt = H_SHIFT;
        end
      end
      H_SHIFT: begin
        div_nxt = div_r + 3'h1;
        if (div_r == 3'(CLK_DIV - 1)) begin
          div_nxt = '0;
          if (!sck_r) begin
            if (left_r == '0) begin
              sess_nxt = 1'b1;
              st_nxt = H_SESSION;
            end else begin
              dat_nxt = sh_r[53];
              sh_nxt = {sh_r[52:0], 1'b0};
              sck_nxt = 1'b1;
              left_nxt = left_r - 6'h01;
            end
          end else begin
            sck_nxt = 1'b0;
          end
        end
      end
      H_SESSION: begin
        rstPin_nxt = hv_r; // RULE6
        if (stop) begin
          hv_nxt = 1'b0;
          rstPin_nxt = 1'b1;
          sess_nxt = 1'b0;
          oe_nxt = 1'b0;
          st_nxt = H_IDLE;
        end else if (sendReq) begin
          sh_nxt = {sendCmd, sendData, 32'h0000_0000};
          left_nxt = sendHasData ? 6'(CMD_BITS + WORD_BITS) : 6'(CMD_BITS);
          div_nxt = '0;
          st_nxt = H_SHIFT;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
    // Busy is registered so that the output comes from a flip-flop.
    busy_nxt = (st_nxt == H_SHIFT);
  end

  // State registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= H_IDLE;
      sh_r <= '0;
      left_r <= 6'h00;
      div_r <= 3'h0;
      sck_r <= 1'b0;
      dat_r <= 1'b0;
      oe_r <= 1'b0;
      rstPin_r <= 1'b1;
      hv_r <= 1'b0;
      sess_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      left_r <= left_nxt;
      div_r <= div_nxt;
      sck_r <= sck_nxt;
      dat_r <= dat_nxt;
      oe_r <= oe_nxt;
      rstPin_r <= rstPin_nxt;
      hv_r <= hv_nxt;
      sess_r <= sess_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign link.progSerialClock = sck_r; // RULE1
  assign link.dataFromHost = dat_r;
  assign link.dataHostOe = oe_r;
  assign link.resetPinLevel = rstPin_r;
  assign link.highVoltage = hv_r;
  assign busy = busy_r;
  assign inSession = sess_r;
endmodule // prog_entry_host
`default_nettype wire

/* File: prog_entry_monitor.sv */
// Checker for the programming entry link and the device mode outputs.
`timescale 1ns/1ps
`default_nettype none
module prog_entry_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic dataDevOe,
  input wire logic resetPinLevel,
  input wire logic highVoltage,
  input wire logic resetDisableCfg,
  input wire logic lowVoltageProgEnable,
  input wire logic externalResetPinEnable,
  input wire logic progMode,
  input wire logic hvSession,
  input wire logic writeStrobe
);
  // All checks share the system clock and its reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // The mode must be gone within a few cycles of the session ending.
  sequence s_leave;
    ##[0:5] !progMode;
  endsequence
  a_dev_no_drive: assert property (!dataDevOe)
    else $error("device drove the data line");
  a_lv_hold_reset: assert property (progMode && !hvSession && resetPinLevel
    |-> s_leave)
    else $error("low-voltage mode kept with reset pin high");
  a_hv_drop_exit: assert property (progMode && hvSession && !highVoltage
    |-> s_leave)
    else $error("high-voltage mode kept without high voltage");
  a_hv_entry_level: assert property ($rose(progMode) && hvSession
    |-> highVoltage)
    else $error("high-voltage entry without high voltage");
  a_lv_entry_enabled: assert property ($rose(progMode) && !hvSession
    |-> lowVoltageProgEnable)
    else $error("low-voltage entry with enable bit clear");
  a_ext_reset_forced: assert property (1'b1 |=> externalResetPinEnable ==
    ($past(lowVoltageProgEnable) || !$past(resetDisableCfg)))
    else $error("external reset enable wrong");
  a_enable_clear_hv: assert property ($fell(lowVoltageProgEnable)
    |-> hvSession)
    else $error("enable bit cleared outside high-voltage session");
  a_strobe_in_mode: assert property (writeStrobe
    |-> progMode ##1 !writeStrobe)
    else $error("write strobe outside mode or too long");
endmodule // prog_entry_monitor
`default_nettype wire

/* File: test_serial_programming_entry.sv */
// Testbench joining programmer and device ends over the serial link.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t got %0h exp %0h", $time, g, e); end end
module test_serial_programming_entry;
  import prog_entry_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic resetDisableCfg = 1'b1;
  logic startLv = 1'b0, startHv = 1'b0, stop = 1'b0, sendReq = 1'b0;
  logic [CMD_BITS-1:0] sendCmd = 6'h00;
  logic sendHasData = 1'b0;
  logic [WORD_BITS-1:0] sendData = 16'h0000;
  logic busy, inSession, lvEnable, extEn, progMode, hvSession, writeStrobe;
  logic [1:0] writeKind;
  logic [WORD_BITS-1:0] writeData;
  int errors = 0;
  int cmp_count = 0;
  int strobes = 0;
  logic [5:0] cmds [3] = '{CMD_WRITE_PROG, CMD_WRITE_ID, CMD_WRITE_CFG};
  logic [1:0] kinds [3] = '{WR_PROG, WR_ID, WR_CFG};
  // Clock of 10 ns period.
  always #5 clk = ~clk;
  // Counts the write strobes that the device gives out.
  always @(posedge clk) begin
    if (writeStrobe === 1'b1) begin
      strobes++;
    end
  end
  prog_link_if link ();
  prog_entry_device u_prog_entry_device (.clk(clk), .rst(rst), .link(link),
    .resetDisableCfg(resetDisableCfg), .lowVoltageProgEnable(lvEnable),
    .externalResetPinEnable(extEn), .progMode(progMode),
    .hvSession(hvSession), .writeStrobe(writeStrobe),
    .writeKind(writeKind), .writeData(writeData));
  prog_entry_host u_prog_entry_host (.clk(clk), .rst(rst), .link(link),
    .startLv(startLv), .startHv(startHv), .stop(stop), .sendReq(sendReq),
    .sendCmd(sendCmd), .sendHasData(sendHasData), .sendData(sendData),
    .busy(busy), .inSession(inSession));
  prog_entry_monitor u_prog_entry_monitor (.clk(clk), .rst(rst),
    .dataDevOe(link.dataDevOe), .resetPinLevel(link.resetPinLevel),
    .highVoltage(link.highVoltage), .resetDisableCfg(resetDisableCfg),
    .lowVoltageProgEnable(lvEnable), .externalResetPinEnable(extEn),
    .progMode(progMode), .hvSession(hvSession), .writeStrobe(writeStrobe));
  // Waits for the host to finish shifting, then lets the device settle.
  task automatic settle();
    int i;
    repeat (2) @(negedge clk);
    for (i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk);
    repeat (12) @(negedge clk);
  endtask
  // Pulses one host request for a single cycle.
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    settle();
  endtask
  // Sends one command with an optional 16-bit word.
  task automatic send(input logic [5:0] c, input logic d,
                      input logic [15:0] w);
    @(negedge clk);
    sendCmd = c;
    sendHasData = d;
    sendData = w;
    sendReq = 1'b1;
    @(negedge clk);
    sendReq = 1'b0;
    settle();
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #300000;
    errors++;
    conclude();
  end
  // Main test sequence.
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK(lvEnable, 1'b1)
    `CHK(extEn, 1'b1)
    `CHK(progMode, 1'b0)
    pulse(startLv);
    `CHK(progMode, 1'b1)
    `CHK(hvSession, 1'b0)
    `CHK(inSession, 1'b1)
    for (int i = 0; i < 3; i++) begin
      send(cmds[i], 1'b1, 16'hA5C3 ^ 16'(i));
      `CHK(writeKind, kinds[i])
      `CHK(writeData, 16'hA5C3 ^ 16'(i))
    end
    send(6'h3F, 1'b0, 16'h0000);
    `CHK(writeData, 16'hA5C1)
    `CHK(strobes, 3)
    send(CMD_CLEAR_LV_ENABLE, 1'b0, 16'h0000);
    `CHK(lvEnable, 1'b1)
    `CHK(extEn, 1'b1)
    pulse(stop);
    `CHK(progMode, 1'b0)
    `CHK(inSession, 1'b0)
    $display("low-voltage session test done");
    pulse(startHv);
    `CHK(progMode, 1'b1)
    `CHK(hvSession, 1'b1)
    send(CMD_CLEAR_LV_ENABLE, 1'b0, 16'h0000);
    `CHK(lvEnable, 1'b0)
    `CHK(extEn, 1'b0)
    pulse(stop);
    `CHK(progMode, 1'b0)
    $display("high-voltage session test done");
    pulse(startLv);
    `CHK(progMode, 1'b0)
    pulse(stop);
    resetDisableCfg = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(extEn, 1'b1)
    $display("disabled low-voltage entry test done");
    conclude();
  end
endmodule // test_serial_programming_entry
`default_nettype wire
